// >>> src/rbt_pkg.sv
// shared constants and carriers for the registered bus transceiver
package rbt_pkg;

	// geometry: two independent halves of eight bits each
	localparam int HALVES   = 2;
	localparam int HALF_W   = 8;
	localparam int SNAP_W   = 2 * HALVES * HALF_W;   // both stored registers of every half

	// wishbone geometry
	localparam int WB_ADR_W = 4;                     // byte address, word aligned
	localparam int WB_DAT_W = 32;
	localparam int WB_SEL_W = 4;

	// register byte offsets
	localparam logic [WB_ADR_W-1:0] ADR_CTRL   = 4'h0;   // control, read/write
	localparam logic [WB_ADR_W-1:0] ADR_STORED = 4'h4;   // stored register contents, read only
	localparam logic [WB_ADR_W-1:0] ADR_STATUS = 4'h8;   // status, overflow is write one to clear

	// field positions and reset values
	localparam int CTRL_ALLOW_BIT = 0;                   // 1 lets the pin enables drive the buses
	localparam int STAT_OVF_BIT   = 0;                   // snapshot buffer overflow, sticky
	localparam int STAT_CTL_LSB   = 8;                   // filtered control pins of all halves
	localparam logic CTRL_ALLOW_RST = 1'b1;

	// control pins of one half
	typedef struct packed {
		logic a_register_capture_clock;
		logic b_register_capture_clock;
		logic a_to_b_drive_enable;
		logic b_to_a_drive_enable_n;
		logic a_to_b_source_select;
		logic b_to_a_source_select;
	} rbt_ctl_s;

	// idle controls: no clocks, neither bus driven
	localparam rbt_ctl_s CTL_IDLE = 6'h04;
	localparam int CTL_W = $bits(rbt_ctl_s) * HALVES;

	// everything sampled from the pins
	typedef struct packed {
		rbt_ctl_s [HALVES-1:0]              ctl;
		logic [HALVES-1:0][HALF_W-1:0]      a;
		logic [HALVES-1:0][HALF_W-1:0]      b;
	} rbt_pins_s;

	localparam rbt_pins_s PINS_RST = '{ctl: {HALVES{CTL_IDLE}}, a: '0, b: '0};

	// drive side of both buses, per bit value and enable
	typedef struct packed {
		logic [HALVES-1:0][HALF_W-1:0]      a_out;
		logic [HALVES-1:0][HALF_W-1:0]      a_oe;
		logic [HALVES-1:0][HALF_W-1:0]      b_out;
		logic [HALVES-1:0][HALF_W-1:0]      b_oe;
	} rbt_drive_s;

	// whole state of the transceiver
	typedef struct packed {
		rbt_pins_s                          s1;
		rbt_pins_s                          s2;
		rbt_pins_s                          s3;
		rbt_pins_s                          filt;
		logic [HALVES-1:0][HALF_W-1:0]      reg_a;
		logic [HALVES-1:0][HALF_W-1:0]      reg_b;
		rbt_drive_s                         drv;
		logic                               allow;
		logic                               ovf;
		logic                               ack;
		logic [WB_DAT_W-1:0]                dat;
		logic [SNAP_W-1:0]                  buf0;
		logic [SNAP_W-1:0]                  buf1;
		logic                               v0;
		logic                               v1;
		logic                               fill_rdy;
	} rbt_state_s;

endpackage

// >>> src/rbt_transceiver.sv
// The placing of the registers and the Wishbone register port are this design's own decisions.
module rbt_transceiver
	import rbt_pkg::*;
(
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	// bus control pins, one group per half
	input  wire rbt_ctl_s [HALVES-1:0]         bus_ctl,
	// two-way data pins, split into input, output and enable
	input  wire logic [HALVES-1:0][HALF_W-1:0] bus_a_in,
	output logic [HALVES-1:0][HALF_W-1:0]      bus_a_out,
	output logic [HALVES-1:0][HALF_W-1:0]      bus_a_oe,
	input  wire logic [HALVES-1:0][HALF_W-1:0] bus_b_in,
	output logic [HALVES-1:0][HALF_W-1:0]      bus_b_out,
	output logic [HALVES-1:0][HALF_W-1:0]      bus_b_oe,
	// snapshot stream of stored registers
	output logic [SNAP_W-1:0]                  snap_data,
	output logic                               snap_valid,
	input  wire logic                          snap_ready,
	output logic                               snap_fill_ready,
	// classic wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [WB_ADR_W-1:0]           wb_adr_i,
	input  wire logic [WB_SEL_W-1:0]           wb_sel_i,
	input  wire logic [WB_DAT_W-1:0]           wb_dat_i,
	output logic [WB_DAT_W-1:0]                wb_dat_o,
	output logic                               wb_ack_o
);

	rbt_state_s st_q;       // all registered state
	rbt_state_s st_d;       // its next value
	rbt_pins_s  pins_now;   // raw pin levels, not yet synchronised

	// gather the pins into one carrier for the synchroniser
	assign pins_now = '{ctl: bus_ctl, a: bus_a_in, b: bus_b_in};

	// a bit follows its pin only when stages two and three agree
	function automatic rbt_pins_s agree(rbt_pins_s s2, rbt_pins_s s3, rbt_pins_s f);
		agree = rbt_pins_s'((s2 & s3) | (f & (s2 ^ s3)));
	endfunction

	// packs both stored registers of every half into one word
	function automatic logic [SNAP_W-1:0] stored_word(
		logic [HALVES-1:0][HALF_W-1:0] ra,
		logic [HALVES-1:0][HALF_W-1:0] rb
	);
		stored_word = '0;
		for (int h = 0; h < HALVES; h++)
		begin
			stored_word[(2*h)*HALF_W +: HALF_W]   = ra[h];
			stored_word[(2*h+1)*HALF_W +: HALF_W] = rb[h];
		end
	endfunction

	// next-state logic for the whole block
	always_comb
	begin
		logic                  wb_hit;    // request taken this cycle
		logic                  push;      // a capture happened somewhere
		logic                  a_rise;    // capture clock edge seen, A register
		logic                  b_rise;    // capture clock edge seen, B register
		rbt_ctl_s              c;         // filtered controls of the half
		logic                  drv_b;     // B bus driven by this half
		logic                  drv_a;     // A bus driven by this half
		logic [SNAP_W-1:0]     snap;      // snapshot after this cycle's captures
		wb_hit = 1'b0;
		push   = 1'b0;
		a_rise = 1'b0;
		b_rise = 1'b0;
		c      = CTL_IDLE;
		drv_b  = 1'b0;
		drv_a  = 1'b0;
		snap   = '0;
		st_d   = st_q;

		// three-stage synchroniser; stage one feeds stage two only
		st_d.s1   = pins_now;
		st_d.s2   = st_q.s1;
		st_d.s3   = st_q.s2;
		st_d.filt = agree(st_q.s2, st_q.s3, st_q.filt);

		// halves share only the global drive allow and the combined capture push into the snapshot buffer
		for (int h = 0; h < HALVES; h++)
		begin
			c = st_q.filt.ctl[h];
			// edges taken from the filtered clock, data from the cycle before the edge
			a_rise = st_d.filt.ctl[h].a_register_capture_clock & ~c.a_register_capture_clock;
			b_rise = st_d.filt.ctl[h].b_register_capture_clock & ~c.b_register_capture_clock;
			// capture ignores selects and enables entirely
			if (a_rise)
			begin
				st_d.reg_a[h] = st_q.filt.a[h];
			end
			if (b_rise)
			begin
				st_d.reg_b[h] = st_q.filt.b[h];
			end
			// no edge: the register is simply not written, so it holds
			push = push | a_rise | b_rise;

			// enables: B side is active high, A side is active low
			drv_b = st_q.allow & c.a_to_b_drive_enable;
			drv_a = st_q.allow & ~c.b_to_a_drive_enable_n;
			st_d.drv.b_oe[h] = {HALF_W{drv_b}};
			st_d.drv.a_oe[h] = {HALF_W{drv_a}};

			// source selects: low passes live bus, high the stored register
			if (c.a_to_b_source_select)
			begin
				st_d.drv.b_out[h] = st_q.reg_a[h];
			end
			else
			begin
				// live A copied back onto B; with A live too, each bus gets the other's last value
				st_d.drv.b_out[h] = st_q.filt.a[h];
			end
			if (c.b_to_a_source_select)
			begin
				st_d.drv.a_out[h] = st_q.reg_b[h];
			end
			else
			begin
				st_d.drv.a_out[h] = st_q.filt.b[h];
			end
		end

		// wishbone: one ack per request, dropped the cycle after
		wb_hit   = wb_cyc_i & wb_stb_i & ~st_q.ack;
		st_d.ack = wb_hit;
		st_d.dat = '0;
		if (wb_hit)
		begin
			case (wb_adr_i)
				ADR_CTRL:
				begin
					st_d.dat[CTRL_ALLOW_BIT] = st_q.allow;
					if (wb_we_i && wb_sel_i[0])
					begin
						st_d.allow = wb_dat_i[CTRL_ALLOW_BIT];
					end
				end
				ADR_STORED:
				begin
					// read only, writes ignored
					st_d.dat = stored_word(st_q.reg_a, st_q.reg_b);
				end
				ADR_STATUS:
				begin
					st_d.dat[STAT_OVF_BIT] = st_q.ovf;
					st_d.dat[STAT_CTL_LSB +: CTL_W] = st_q.filt.ctl;
					// write one clears; a capture into a full buffer this cycle sets again below
					if (wb_we_i && wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT])
					begin
						st_d.ovf = 1'b0;
					end
				end
				default:
				begin
					// unmapped: acked, reads zero, writes dropped
					st_d.dat = '0;
				end
			endcase
		end

		// two-entry buffer: pop first so a full buffer frees a slot this cycle
		if (st_q.v0 && snap_ready)
		begin
			st_d.buf0 = st_q.buf1;
			st_d.v0   = st_q.v1;
			st_d.v1   = 1'b0;
		end
		// pin clocks cannot be stalled, so a push into a full buffer is flagged
		snap = stored_word(st_d.reg_a, st_d.reg_b);
		if (push)
		begin
			if (!st_d.v0)
			begin
				st_d.buf0 = snap;
				st_d.v0   = 1'b1;
			end
			else if (!st_d.v1)
			begin
				st_d.buf1 = snap;
				st_d.v1   = 1'b1;
			end
			else
			begin
				st_d.ovf = 1'b1;
			end
		end
		// ready toward the capturing side: a slot is still free
		st_d.fill_rdy = ~st_d.v1;
	end

	// one register stage for all state
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q       <= '0;
			st_q.s1    <= PINS_RST;
			st_q.s2    <= PINS_RST;
			st_q.s3    <= PINS_RST;
			st_q.filt  <= PINS_RST;
			st_q.allow <= CTRL_ALLOW_RST;
			st_q.fill_rdy <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign bus_a_out       = st_q.drv.a_out;
	assign bus_a_oe        = st_q.drv.a_oe;
	assign bus_b_out       = st_q.drv.b_out;
	assign bus_b_oe        = st_q.drv.b_oe;
	assign snap_data       = st_q.buf0;
	assign snap_valid      = st_q.v0;
	assign snap_fill_ready = st_q.fill_rdy;
	assign wb_dat_o        = st_q.dat;
	assign wb_ack_o        = st_q.ack;

	// helper views of halves zero and one for the checks below
	rbt_ctl_s f0;   // filtered controls, half zero
	assign f0 = st_q.filt.ctl[0];
	rbt_ctl_s f1;   // filtered controls, half one
	assign f1 = st_q.filt.ctl[1];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	// captured value equals the bus one cycle before the edge
	capture_a_value_a: assert property (
		$rose(f0.a_register_capture_clock) |-> st_q.reg_a[0] == $past(st_q.filt.a[0]))
		else $error("A register missed its capture");

	capture_b_value_a: assert property (
		$rose(f0.b_register_capture_clock) |-> st_q.reg_b[0] == $past(st_q.filt.b[0]))
		else $error("B register missed its capture");

	// no edge, no change
	hold_a_steady_a: assert property (
		!$rose(f0.a_register_capture_clock) |-> $stable(st_q.reg_a[0]))
		else $error("A register changed without a clock edge");

	hold_b_steady_a: assert property (
		!$rose(f0.b_register_capture_clock) |-> $stable(st_q.reg_b[0]))
		else $error("B register changed without a clock edge");

	// isolation releases both buses
	isolation_release_a: assert property (
		(!f0.a_to_b_drive_enable && f0.b_to_a_drive_enable_n)
		|=> (st_q.drv.a_oe[0] == '0 && st_q.drv.b_oe[0] == '0))
		else $error("bus driven while isolated");

	// stored B onto A
	stored_b_to_a_a: assert property (
		(st_q.allow && !f0.b_to_a_drive_enable_n && f0.b_to_a_source_select)
		|=> (&st_q.drv.a_oe[0] && st_q.drv.a_out[0] == $past(st_q.reg_b[0])))
		else $error("A bus not driven from stored B");

	// live A onto B
	live_a_to_b_a: assert property (
		(st_q.allow && f0.a_to_b_drive_enable && !f0.a_to_b_source_select)
		|=> (&st_q.drv.b_oe[0] && st_q.drv.b_out[0] == $past(st_q.filt.a[0])))
		else $error("B bus not driven from live A");

	// stored A onto B, select high
	stored_to_b_a: assert property (
		(st_q.allow && f0.a_to_b_drive_enable && f0.a_to_b_source_select)
		|=> (&st_q.drv.b_oe[0] && st_q.drv.b_out[0] == $past(st_q.reg_a[0])))
		else $error("B bus not driven from stored A");

	// live B onto A, select low
	live_to_a_a: assert property (
		(st_q.allow && !f0.b_to_a_drive_enable_n && !f0.b_to_a_source_select)
		|=> (&st_q.drv.a_oe[0] && st_q.drv.a_out[0] == $past(st_q.filt.b[0])))
		else $error("A bus not driven from live B");

	// both stored, crossed
	cross_stored_a: assert property (
		(st_q.allow && f0.a_to_b_drive_enable && !f0.b_to_a_drive_enable_n
			&& f0.a_to_b_source_select && f0.b_to_a_source_select)
		|=> (st_q.drv.b_out[0] == $past(st_q.reg_a[0])
			&& st_q.drv.a_out[0] == $past(st_q.reg_b[0])))
		else $error("crossed stored transfer wrong");

	// both enables high: only B driven
	enables_high_a: assert property (
		(st_q.allow && f0.a_to_b_drive_enable && f0.b_to_a_drive_enable_n)
		|=> (&st_q.drv.b_oe[0] && st_q.drv.a_oe[0] == '0))
		else $error("wrong direction with both enables high");

	// both enables low: only A driven
	enables_low_a: assert property (
		(st_q.allow && !f0.a_to_b_drive_enable && !f0.b_to_a_drive_enable_n)
		|=> (&st_q.drv.a_oe[0] && st_q.drv.b_oe[0] == '0))
		else $error("wrong direction with both enables low");

	// live both ways: each bus gets the other's last value
	reinforce_live_a: assert property (
		(st_q.allow && f0.a_to_b_drive_enable && !f0.b_to_a_drive_enable_n
			&& !f0.a_to_b_source_select && !f0.b_to_a_source_select)
		|=> (st_q.drv.b_out[0] == $past(st_q.filt.a[0])
			&& st_q.drv.a_out[0] == $past(st_q.filt.b[0])))
		else $error("live loop does not reinforce");

	// half one decodes its own pins, not those of half zero
	half_one_iso_a: assert property (
		(!f1.a_to_b_drive_enable && f1.b_to_a_drive_enable_n)
		|=> (st_q.drv.a_oe[1] == '0 && st_q.drv.b_oe[1] == '0))
		else $error("half one driven while isolated");

	// allow off overrides the pins, so software can always free the buses
	allow_off_release_a: assert property (
		!st_q.allow |=> (st_q.drv.a_oe == '0 && st_q.drv.b_oe == '0))
		else $error("bus driven while drive allow is off");

	// wishbone answers in one cycle and drops ack next
	wb_single_ack_a: assert property (
		(wb_cyc_i && wb_stb_i && !st_q.ack) |=> st_q.ack ##1 !st_q.ack)
		else $error("wishbone ack timing wrong");

	// main scenarios
	isolation_seen_c: cover property (
		!f0.a_to_b_drive_enable && f0.b_to_a_drive_enable_n);
	cross_stored_seen_c: cover property (
		f0.a_to_b_drive_enable && !f0.b_to_a_drive_enable_n
		&& f0.a_to_b_source_select && f0.b_to_a_source_select);
	capture_seen_c: cover property ($rose(f0.a_register_capture_clock));
	overflow_seen_c: cover property ($rose(st_q.ovf));
	latch_seen_c: cover property (
		f0.a_to_b_drive_enable && !f0.b_to_a_drive_enable_n
		&& !f0.a_to_b_source_select && !f0.b_to_a_source_select);

endmodule // rbt_transceiver

// >>> verification/rbt_bus_model.sv
// far side of both data buses: one plain driver per bus, wires resolved here
module rbt_bus_model
	import rbt_pkg::*;
(
	input  wire logic                          core_clk,
	input  wire logic [HALVES-1:0][HALF_W-1:0] dut_a_out,
	input  wire logic [HALVES-1:0][HALF_W-1:0] dut_a_oe,
	input  wire logic [HALVES-1:0][HALF_W-1:0] dut_b_out,
	input  wire logic [HALVES-1:0][HALF_W-1:0] dut_b_oe,
	input  wire logic [HALVES-1:0][HALF_W-1:0] far_a,
	input  wire logic [HALVES-1:0][HALF_W-1:0] far_a_en,
	input  wire logic [HALVES-1:0][HALF_W-1:0] far_b,
	input  wire logic [HALVES-1:0][HALF_W-1:0] far_b_en,
	output logic [HALVES-1:0][HALF_W-1:0]      a_in,
	output logic [HALVES-1:0][HALF_W-1:0]      b_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [HALVES-1:0][HALF_W-1:0] a_last_q = '0;   // last resolved a level
	logic [HALVES-1:0][HALF_W-1:0] b_last_q = '0;   // last resolved b level
	// remember levels so a released line can wander
	always @(posedge core_clk)
	begin
		a_last_q <= a_in;
		b_last_q <= b_in;
	end
	// device drive first, then far driver, else a floating line flips each cycle
	// so a design that stops reinforcing cannot keep its value by luck
	assign a_in = (dut_a_oe & dut_a_out) | (~dut_a_oe & far_a_en & far_a)
		| (~dut_a_oe & ~far_a_en & ~a_last_q);
	assign b_in = (dut_b_oe & dut_b_out) | (~dut_b_oe & far_b_en & far_b)
		| (~dut_b_oe & ~far_b_en & ~b_last_q);
endmodule // rbt_bus_model

// >>> verification/tb_top.sv
// bench: wishbone register access plus pin control sequences
module tb_top
	import rbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                          core_clk = 1'b0;   // 100 mhz
	logic                          nrst = 1'b0;       // active low reset
	rbt_ctl_s [HALVES-1:0]         ctl = {HALVES{CTL_IDLE}};
	logic [HALVES-1:0][HALF_W-1:0] far_a = '0, far_a_en = '0, far_b = '0, far_b_en = '0;
	logic [HALVES-1:0][HALF_W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic [SNAP_W-1:0]             snap_data;         // stream head word
	logic                          snap_valid, snap_fill_ready;
	logic                          snap_ready = 1'b0;  // sink stalls at start
	logic                          cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [WB_ADR_W-1:0]           adr = '0;
	logic [WB_SEL_W-1:0]           sel = 4'hf;
	logic [WB_DAT_W-1:0]           wdat = '0, wb_dat_o, rd;
	logic                          wb_ack_o;
	int                            err_count = 0, comparisons = 0, cyc_cnt = 0;
	always #5 core_clk = ~core_clk;
	rbt_transceiver dut (.core_clk(core_clk), .nrst(nrst), .bus_ctl(ctl),
		.bus_a_in(a_in), .bus_a_out(a_out), .bus_a_oe(a_oe),
		.bus_b_in(b_in), .bus_b_out(b_out), .bus_b_oe(b_oe),
		.snap_data(snap_data), .snap_valid(snap_valid), .snap_ready(snap_ready),
		.snap_fill_ready(snap_fill_ready), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	rbt_bus_model far (.core_clk(core_clk), .dut_a_out(a_out), .dut_a_oe(a_oe),
		.dut_b_out(b_out), .dut_b_oe(b_oe), .far_a(far_a), .far_a_en(far_a_en),
		.far_b(far_b), .far_b_en(far_b_en), .a_in(a_in), .b_in(b_in));
	// verdict, reached from the main sequence or the hang guard
	task automatic wrap_up();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard: whole sequence needs well under a thousand cycles
	always @(posedge core_clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000)
		begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one classic cycle; request held until ack is sampled
	task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a, input logic [31:0] d,
		input logic [WB_SEL_W-1:0] s = 4'hf);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		// no answer time assumed: only the hang guard ends this wait
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// control pins are filtered, so give them time to settle
	task automatic cs(input int h, input logic [5:0] v);
		@(posedge core_clk);
		ctl[h] <= v;
		repeat (14) @(posedge core_clk);
	endtask
	// pop one snapshot word and compare it
	task automatic pop(input logic [31:0] exp);
		chk("snap_valid", 32'h1, {31'h0, snap_valid});
		chk("snap_data", exp, snap_data);
		snap_ready <= 1'b1;
		@(posedge core_clk);
		snap_ready <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	// ctl bits: aclk bclk ab ba_n sab sba
	initial
	begin
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		wb(0, ADR_CTRL, 0);
		chk("ctrl reset", 32'h1, rd);
		wb(0, ADR_STATUS, 0);
		chk("ovf reset", 32'h0, {31'h0, rd[STAT_OVF_BIT]});
		wb(0, 4'hc, 0);
		chk("unmapped", 32'h0, rd);
		far_a <= {8'ha5, 8'h5a};
		far_b <= {8'hc3, 8'h3c};
		far_a_en <= '1;
		far_b_en <= '1;
		cs(0, 6'h04);
		chk("isolation", 32'h0, {31'h0, |{a_oe, b_oe}});
		cs(0, 6'h24);
		cs(0, 6'h04);
		wb(0, ADR_STORED, 0);
		chk("store a0", 32'h0000005a, rd);
		far_a[0] <= 8'h11;
		cs(0, 6'h04);
		wb(0, ADR_STORED, 0);
		chk("hold a0", 32'h0000005a, rd);
		cs(1, 6'h34);
		cs(1, 6'h04);
		wb(0, ADR_STORED, 0);
		chk("store both", 32'hc3a5005a, rd);
		chk("fill_ready", 32'h0, {31'h0, snap_fill_ready});
		cs(0, 6'h14);
		wb(0, ADR_STATUS, 0);
		chk("ovf set", 32'h1, {31'h0, rd[STAT_OVF_BIT]});
		pop(32'h0000005a);
		pop(32'hc3a5005a);
		chk("drained", 32'h0, {31'h0, snap_valid});
		wb(1, ADR_STATUS, 32'h1);
		wb(0, ADR_STATUS, 0);
		chk("ovf clear", 32'h0, {31'h0, rd[STAT_OVF_BIT]});
		far_b_en[0] <= '0;
		cs(0, 6'h0c);
		chk("b live a", 32'h11ff, {b_in[0], b_oe[0]});
		cs(0, 6'h0e);
		chk("b stored a", 32'h5aff, {b_in[0], b_oe[0]});
		cs(0, 6'h2c);
		cs(0, 6'h1c);
		cs(0, 6'h0c);
		wb(0, ADR_STORED, 0);
		chk("both load", 32'h1111, rd[15:0]);
		far_a_en[0] <= '0;
		far_b[0] <= 8'h77;
		far_b_en[0] <= '1;
		cs(0, 6'h00);
		chk("a live b", 32'h77ff, {a_in[0], a_oe[0]});
		cs(0, 6'h01);
		chk("a stored b", 32'h11ff, {a_in[0], a_oe[0]});
		cs(0, 6'h10);
		cs(0, 6'h00);
		wb(0, ADR_STORED, 0);
		chk("b via a path", 32'h7711, rd[15:0]);
		far_b_en[0] <= '0;
		cs(0, 6'h0b);
		chk("cross", 32'h7711ffff, {a_in[0], b_in[0], a_oe[0], b_oe[0]});
		chk("half1 idle", 32'h0, {a_oe[1], b_oe[1]});
		far_a[0] <= 8'h42;
		far_a_en[0] <= '1;
		cs(0, 6'h0c);
		cs(0, 6'h08);
		far_a_en[0] <= '0;
		repeat (20) @(posedge core_clk);
		chk("latch", 32'h4242, {a_in[0], b_in[0]});
		wb(1, ADR_CTRL, 32'h0);
		repeat (4) @(posedge core_clk);
		chk("allow off", 32'h0, {31'h0, |{a_oe, b_oe}});
		wb(1, ADR_CTRL, 32'h1, 4'he);
		wb(0, ADR_CTRL, 0);
		chk("ctrl sel0 dropped", 32'h0, rd);
		wrap_up();
	end
endmodule // tb_top
